// ---- shared/uefa_defs.vh ----
// uefa_defs.vh: register offsets, field positions, reset values and timing
// counts for the usb event flag, address and frame-low block.
// assumes a 32-bit classic wishbone slave with word-aligned registers.
`ifndef UEFA_DEFS_VH
`define UEFA_DEFS_VH

// register byte offsets
`define UEFA_EVENT_FLAGS_OFS   5'h00
`define UEFA_FUNC_ADDR_OFS     5'h04
`define UEFA_FRAME_LOW_OFS     5'h08
`define UEFA_EVENT_MASK_OFS    5'h0c
`define UEFA_CTRL_OFS          5'h10
`define UEFA_TOKEN_STAT_OFS    5'h14

// event flag positions
`define UEFA_STALL_BIT         7
`define UEFA_ATTACH_BIT        6
`define UEFA_RESUME_BIT        5
`define UEFA_IDLE_BIT          4
`define UEFA_TOKEN_DONE_BIT    3
`define UEFA_FRAME_START_BIT   2
`define UEFA_ERROR_BIT         1
`define UEFA_RESET_DETACH_BIT  0

// address and control register fields
`define UEFA_LOW_SPEED_BIT     7
`define UEFA_ERR_MASK_SHIFT    8

// reset values
`define UEFA_FLAGS_RST         8'h00
`define UEFA_ADDR_RST          8'h00
`define UEFA_FRAME_RST         8'h00
`define UEFA_MASK_RST          8'h00
`define UEFA_CTRL_RST          8'h00

// timing: clock period in ns, 2.5 us and 3 ms figures
`define UEFA_CLK_NS            10
`define UEFA_LINE_QUIET_NS     2500
`define UEFA_IDLE_NS           3000000
// cycle counts at the 10 ns clock; 300000 needs all 19 timer bits
`define UEFA_QUIET_CYC         19'd250
`define UEFA_IDLE_CYC          19'd300000

`endif

// ---- design/uefa_top.v ----
// uefa_top.v: usb event flags, function address and frame number low byte.
// assumes bus-state and event inputs from the usb serial engine on CLK_IN,
// except the raw D+/D- levels, which are asynchronous and synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "uefa_defs.vh"

module uefa_top (
   input  wire        CLK_IN,
   input  wire        RST_B_IN,
   input  wire        WB_CYC_IN,
   input  wire        WB_STB_IN,
   input  wire        WB_WE_IN,
   input  wire [4:0]  WB_ADR_IN,
   input  wire [3:0]  WB_SEL_IN,
   input  wire [31:0] WB_DAT_IN,
   output reg  [31:0] WB_DAT_OUT,
   output reg         WB_ACK_OUT,
   input  wire        DP_IN,
   input  wire        DM_IN,
   input  wire        SE0_IN,
   input  wire        BUS_IDLE_IN,
   input  wire        SUSPENDED_IN,
   input  wire        STALL_RX_IN,
   input  wire        STALL_TX_IN,
   input  wire        ATTACH_IN,
   input  wire        DETACH_IN,
   input  wire        BUS_RESET_IN,
   input  wire        SOF_RX_IN,
   input  wire        SOF_THRESH_IN,
   input  wire [10:0] FRAME_NUM_IN,
   input  wire [7:0]  ERROR_EVENTS_IN,
   input  wire        TOKEN_DONE_IN,
   input  wire [7:0]  TOKEN_STAT_IN,
   input  wire        TOKEN_PENDING_IN,
   output wire        TOKEN_FIFO_POP_OUT,
   output wire        HOST_ROLE_OUT,
   output wire        LOW_SPEED_OUT,
   output wire [6:0]  FUNC_ADDR_OUT,
   output wire [7:0]  ERR_ENABLE_OUT,
   output wire        IRQ_OUT
);

   reg        rst_s1;
   reg        rst_n;
   wire       dp_level;
   wire       dm_level;
   wire [7:0] flags;
   reg  [7:0] mask;
   reg  [7:0] addr;
   reg  [7:0] frame_low;
   reg  [7:0] ctrl;
   reg  [7:0] err_en;
   reg  [7:0] token_stat;
   reg  [7:0] set_vec;
   reg  [7:0] clr_vec;
   reg  [7:0] rd_data;
   wire       k_hit;
   wire       quiet_full;
   wire       idle_hit;

   wire       host_role = ctrl[0];
   wire       bus_req   = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   wire       wr_req    = bus_req & WB_WE_IN & WB_SEL_IN[0];
   // address decode; the word index sits in bits 4-2
   wire [4:0] ofs       = {WB_ADR_IN[4:2], 2'b00};
   wire       sel_flags = (ofs == `UEFA_EVENT_FLAGS_OFS);
   wire       sel_addr  = (ofs == `UEFA_FUNC_ADDR_OFS);
   wire       sel_mask  = (ofs == `UEFA_EVENT_MASK_OFS);
   wire       sel_ctrl  = (ofs == `UEFA_CTRL_OFS);
   wire       flag_wr   = wr_req & sel_flags;
   // k-state: full speed D- high, low speed D+ high, both with no se0
   wire       k_state   = addr[`UEFA_LOW_SPEED_BIT] ? (dp_level & ~dm_level)
                                                    : (dm_level & ~dp_level);
   // timers run only while their bus condition holds and clear otherwise
   wire       k_run     = k_state & ~SE0_IN;
   wire       quiet_run = BUS_IDLE_IN & ~SE0_IN;
   wire       idle_run  = BUS_IDLE_IN;

   // reset release through two flops, so every flop on rst_n leaves reset together
   always @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // pin levels accepted only once stages two and three agree
   uefa_pin_sync i_dp_sync (
      .clk_in    (CLK_IN),
      .rst_b_in  (rst_n),
      .pin_in    (DP_IN),
      .level_out (dp_level)
   );

   uefa_pin_sync i_dm_sync (
      .clk_in    (CLK_IN),
      .rst_b_in  (rst_n),
      .pin_in    (DM_IN),
      .level_out (dm_level)
   );

   // bus timers saturate, so the k and idle conditions fire once per episode; quiet_full stays high while the bus stays quiet
   // the idle timer is long; a run of bus activity restarts it
   uefa_run_timer #(
      .LIMIT     (`UEFA_QUIET_CYC)
   ) i_k_timer (
      .clk_in    (CLK_IN),
      .rst_b_in  (rst_n),
      .run_in    (k_run),
      .full_out  (),
      .reach_out (k_hit)
   );

   uefa_run_timer #(
      .LIMIT     (`UEFA_QUIET_CYC)
   ) i_quiet_timer (
      .clk_in    (CLK_IN),
      .rst_b_in  (rst_n),
      .run_in    (quiet_run),
      .full_out  (quiet_full),
      .reach_out ()
   );

   uefa_run_timer #(
      .LIMIT     (`UEFA_IDLE_CYC)
   ) i_idle_timer (
      .clk_in    (CLK_IN),
      .rst_b_in  (rst_n),
      .run_in    (idle_run),
      .full_out  (),
      .reach_out (idle_hit)
   );

   always @* begin
      set_vec = 8'h00;
      set_vec[`UEFA_STALL_BIT] = host_role ? STALL_RX_IN : STALL_TX_IN;
      set_vec[`UEFA_ATTACH_BIT] = host_role & ATTACH_IN & quiet_full;
      set_vec[`UEFA_RESUME_BIT] = k_hit;
      set_vec[`UEFA_IDLE_BIT] = idle_hit;
      set_vec[`UEFA_TOKEN_DONE_BIT] = TOKEN_DONE_IN;
      set_vec[`UEFA_FRAME_START_BIT] = host_role ? SOF_THRESH_IN
                                                 : SOF_RX_IN;
      set_vec[`UEFA_ERROR_BIT] = |(ERROR_EVENTS_IN & err_en);
      set_vec[`UEFA_RESET_DETACH_BIT] = host_role ? DETACH_IN
                                                  : BUS_RESET_IN;
      clr_vec = flag_wr ? WB_DAT_IN[7:0] : 8'h00;
      clr_vec[`UEFA_ERROR_BIT] = 1'b0;
   end

   // one sticky cell per event flag
   genvar b;
   generate
      for (b = 0; b < 8; b = b + 1) begin : g_flag
         uefa_flag_bit i_uefa_flag_bit (
            .clk_in   (CLK_IN),
            .rst_b_in (rst_n),
            .set_in   (set_vec[b]),
            .clr_in   (clr_vec[b]),
            .flag_out (flags[b])
         );
      end
   endgenerate

   // token fifo pops when a set token-done flag is written clear
   assign TOKEN_FIFO_POP_OUT = flag_wr & flags[`UEFA_TOKEN_DONE_BIT] &
                               WB_DAT_IN[`UEFA_TOKEN_DONE_BIT];

   // event-side captures
   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         token_stat <= 8'h00;
      else if (TOKEN_DONE_IN)
         token_stat <= TOKEN_STAT_IN;
   end

   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         frame_low <= `UEFA_FRAME_RST;
      else if (SOF_RX_IN)
         frame_low <= FRAME_NUM_IN[7:0];
   end

   // software registers; byte lane 0 carries them
   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         addr <= `UEFA_ADDR_RST;
      else if (wr_req & sel_addr)
         addr <= WB_DAT_IN[7:0];
   end

   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         mask <= `UEFA_MASK_RST;
      else if (wr_req & sel_mask)
         mask <= WB_DAT_IN[7:0];
   end

   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         ctrl <= `UEFA_CTRL_RST;
      else if (wr_req & sel_ctrl)
         ctrl <= WB_DAT_IN[7:0];
   end

   // error enables sit in lane 1 of the control word
   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         err_en <= `UEFA_MASK_RST;
      else if (bus_req & WB_WE_IN & WB_SEL_IN[1] & sel_ctrl)
         err_en <= WB_DAT_IN[15:8];
   end

   // read mux; unmapped words read zero and still ack
   always @* begin
      case (ofs)
         `UEFA_EVENT_FLAGS_OFS: rd_data = flags;
         `UEFA_FUNC_ADDR_OFS:   rd_data = addr;
         `UEFA_FRAME_LOW_OFS:   rd_data = frame_low;
         `UEFA_EVENT_MASK_OFS:  rd_data = mask;
         `UEFA_CTRL_OFS:        rd_data = ctrl;
         `UEFA_TOKEN_STAT_OFS:  rd_data = TOKEN_PENDING_IN ? token_stat
                                                           : 8'h00;
         default:               rd_data = 8'h00;
      endcase
   end

   // one wait-free ack per request, dropped the cycle after
   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         WB_ACK_OUT <= 1'b0;
      else
         WB_ACK_OUT <= bus_req;
   end

   // read data holds until the next request, so a slow master still sees it
   always @(posedge CLK_IN or negedge rst_n) begin
      if (!rst_n)
         WB_DAT_OUT <= 32'h0;
      else if (bus_req)
         WB_DAT_OUT <= {24'h0, rd_data};
   end

   assign HOST_ROLE_OUT  = host_role;
   assign LOW_SPEED_OUT  = addr[`UEFA_LOW_SPEED_BIT];
   assign FUNC_ADDR_OUT  = addr[6:0];
   assign ERR_ENABLE_OUT = err_en;
   // resume reaches the line only while suspended; software should keep
   // it masked outside suspend anyway, this gate is the safety net
   wire [7:0] irq_gate = {2'b11, SUSPENDED_IN | ~mask[`UEFA_RESUME_BIT],
                          5'h1f};
   assign IRQ_OUT        = |(flags & mask & irq_gate);

endmodule

// three-flop pin synchroniser; a level moves only when stages two and
// three agree, so one metastable sample cannot reach the timers
module uefa_pin_sync (
   input  wire clk_in,
   input  wire rst_b_in,
   input  wire pin_in,
   output reg  level_out
);
   reg [2:0] stage;

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage     <= 3'h0;
         level_out <= 1'b0;
      end else begin
         stage <= {stage[1:0], pin_in};
         if (stage[2] == stage[1])
            level_out <= stage[2];
      end
   end
endmodule

// saturating run timer: counts while run_in holds and clears when it
// drops; reach_out pulses once, on the cycle before the count reaches the limit
module uefa_run_timer #(
   parameter [18:0] LIMIT = 19'd250
) (
   input  wire clk_in,
   input  wire rst_b_in,
   input  wire run_in,
   output wire full_out,
   output wire reach_out
);
   localparam [18:0] LAST = LIMIT - 19'd1;

   reg [18:0] count;

   assign full_out  = (count == LIMIT);
   assign reach_out = run_in & (count == LAST);

   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         count <= 19'h0;
      else if (!run_in)
         count <= 19'h0;
      else if (count != LIMIT)
         count <= count + 19'h1;
   end
endmodule

// one sticky event flag; a set in the same cycle as a clear wins, so an
// event landing during the software clear is never lost
module uefa_flag_bit (
   input  wire clk_in,
   input  wire rst_b_in,
   input  wire set_in,
   input  wire clr_in,
   output reg  flag_out
);
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         flag_out <= 1'b0;
      else if (set_in)
         flag_out <= 1'b1;
      else if (clr_in)
         flag_out <= 1'b0;
   end
endmodule
`default_nettype wire

// ---- verif/uefa_checker.sv ----
// uefa_checker.sv: bus and register-output assertions for uefa_top.
// assumes it is bound onto uefa_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module uefa_checker (
   input wire logic        CLK_IN,
   input wire logic        RST_B_IN,
   input wire logic        WB_CYC_IN,
   input wire logic        WB_STB_IN,
   input wire logic        WB_WE_IN,
   input wire logic [4:0]  WB_ADR_IN,
   input wire logic [3:0]  WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic        WB_ACK_OUT,
   input wire logic        SUSPENDED_IN,
   input wire logic        TOKEN_FIFO_POP_OUT,
   input wire logic        HOST_ROLE_OUT,
   input wire logic        LOW_SPEED_OUT,
   input wire logic [6:0]  FUNC_ADDR_OUT,
   input wire logic [7:0]  ERR_ENABLE_OUT,
   input wire logic        IRQ_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   wire req = WB_CYC_IN && WB_STB_IN;
   // writes land at the ack edge, so the data is still held there
   wire wr = req && WB_WE_IN && WB_ACK_OUT;
   wire [2:0] w = WB_ADR_IN[4:2];
   property p_ack; req && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
   property p_ack1; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
   property p_ackreq; WB_ACK_OUT |-> $past(req); endproperty
   property p_hi0; WB_ACK_OUT && w != 3'd4 |-> WB_DAT_OUT[31:8] == 0;
   endproperty
   property p_fa; wr && w == 3'd1 && WB_SEL_IN[0] |=>
      {LOW_SPEED_OUT, FUNC_ADDR_OUT} == $past(WB_DAT_IN[7:0]); endproperty
   property p_een; wr && w == 3'd4 && WB_SEL_IN[1] |=>
      ERR_ENABLE_OUT == $past(WB_DAT_IN[15:8]); endproperty
   property p_host; wr && w == 3'd4 && WB_SEL_IN[0] |=>
      HOST_ROLE_OUT == $past(WB_DAT_IN[0]); endproperty
   property p_pop; TOKEN_FIFO_POP_OUT |->
      req && WB_WE_IN && w == 3'd0 && WB_DAT_IN[3]; endproperty
   property p_pop1; TOKEN_FIFO_POP_OUT |=> !TOKEN_FIFO_POP_OUT; endproperty
   // flags are sticky: the line drops only after a write or suspend exit
   property p_irqf; $fell(IRQ_OUT) |->
      $past(req && WB_WE_IN || SUSPENDED_IN); endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   a_ack1: assert property (p_ack1) else $error("ack too long");
   a_ackreq: assert property (p_ackreq) else $error("ack unasked");
   a_hi0: assert property (p_hi0) else $error("upper bits set");
   a_fa: assert property (p_fa) else $error("address reg");
   a_een: assert property (p_een) else $error("error enable");
   a_host: assert property (p_host) else $error("host role");
   a_pop: assert property (p_pop) else $error("stray pop");
   a_pop1: assert property (p_pop1) else $error("long pop");
   a_irqf: assert property (p_irqf) else $error("flag lost");
   c_pop: cover property (TOKEN_FIFO_POP_OUT);
   c_fa: cover property (wr && w == 3'd1);
   c_irq: cover property ($rose(IRQ_OUT));
endmodule
bind uefa_top uefa_checker i_uefa_checker (.*);
`default_nettype wire

// ---- verif/uefa_usb_peer.sv ----
// uefa_usb_peer.sv: serial-engine stand-in driving line levels and pulses.
// assumes the bench raises cmd_in bits for one cycle at a time.
`timescale 1ns/100ps
`default_nettype none
module uefa_usb_peer (
   input  wire logic        clk_in,
   input  wire logic [7:0]  cmd_in,
   input  wire logic        k_in,
   output var  logic [7:0]  ev_out,
   output var  logic [10:0] frame_out,
   output logic             dp_out,
   output logic             dm_out,
   output logic             idle_out
);
   initial ev_out = 8'h00;
   initial frame_out = 11'h5a2;
   // full-speed k pulls d+ low and d- high; j otherwise, never floating
   assign dp_out = !k_in;
   assign dm_out = k_in;
   assign idle_out = !k_in;
   always @(posedge clk_in) begin
      ev_out <= cmd_in;
      if (cmd_in[5]) frame_out <= frame_out + 11'h001;
   end
endmodule
`default_nettype wire

// ---- verif/uefa_top_bench.sv ----
// uefa_top_bench.sv: wishbone register tests of uefa_top.
// assumes uefa_usb_peer in place of the usb serial engine.
`timescale 1ns/100ps
`default_nettype none
module uefa_top_bench;
   logic clk, rst_b = 0, cyc = 0, stb = 0, we = 0, k = 0, susp = 0, pnd = 0;
   logic ack, pop, host, ls, irq, dp, dm, idl;
   logic [4:0] adr = 0;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat = 0, rdat, rv;
   logic [7:0] cmd = 0, err = 0, ev, een;
   logic [6:0] fa;
   logic [10:0] fr;
   int errors, comparisons, i;
   int cm[8] = '{1, 4, 5, 7, 0, 2, 3, 6};
   int bt[8] = '{7, 0, 2, 3, 7, 6, 0, 2};
   uefa_usb_peer i_uefa_usb_peer (.clk_in(clk), .cmd_in(cmd), .k_in(k),
      .ev_out(ev), .frame_out(fr), .dp_out(dp), .dm_out(dm), .idle_out(idl));
   uefa_top i_uefa_top (.CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
      .WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .DP_IN(dp),
      .DM_IN(dm), .SE0_IN(1'b0), .BUS_IDLE_IN(idl), .SUSPENDED_IN(susp),
      .STALL_RX_IN(ev[0]), .STALL_TX_IN(ev[1]), .ATTACH_IN(ev[2]),
      .DETACH_IN(ev[3]), .BUS_RESET_IN(ev[4]), .SOF_RX_IN(ev[5]),
      .SOF_THRESH_IN(ev[6]), .FRAME_NUM_IN(fr), .ERROR_EVENTS_IN(err),
      .TOKEN_DONE_IN(ev[7]), .TOKEN_STAT_IN(8'h3c), .TOKEN_PENDING_IN(pnd),
      .TOKEN_FIFO_POP_OUT(pop), .HOST_ROLE_OUT(host), .LOW_SPEED_OUT(ls),
      .FUNC_ADDR_OUT(fa), .ERR_ENABLE_OUT(een), .IRQ_OUT(irq));
   task automatic chk(input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1 && ++n < 99);
      if (n >= 99) begin
         errors++;
         finish_test;
      end
      rv = rdat;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      wb(0, a, 0);
      chk(rv, e);
   endtask
   task automatic pulse(input int c);
      @(posedge clk);
      cmd <= 8'h01 << c;
      @(posedge clk);
      cmd <= 0;
      repeat (2) @(posedge clk);
   endtask
   task automatic finish_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // a run still going at 100000 ns ends here; wb itself ends a register handshake hang after 99 cycles
   initial begin
      #100000;
      errors++;
      finish_test;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 8; i++) rd(i * 4, 0);
      pnd <= 1;
      wb(1, 5'h04, 32'hffffff85);
      rd(5'h04, 32'h85);
      chk({ls, fa}, 8'h85);
      wb(1, 5'h04, 0);
      wb(1, 5'h0c, 32'hdf);
      for (i = 0; i < 8; i++) begin
         wb(1, 5'h10, i / 4);
         chk(host, i / 4);
         // attach is judged only after a quiet bus in host role
         if (i == 4) repeat (260) @(posedge clk);
         pulse(cm[i]);
         rd(0, 1 << bt[i]);
         chk(irq, 1);
         if (i == 2) rd(5'h08, 32'ha3);
         if (i == 3) rd(5'h14, 32'h3c);
         wb(1, 0, 1 << bt[i]);
         rd(0, 0);
         chk(irq, 0);
      end
      wb(1, 5'h10, 0);
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         err <= 8'h01;
         @(posedge clk);
         err <= 0;
         rd(0, i * 2);
         wb(1, i ? 5'h00 : 5'h10, i ? 32'h2 : 32'h100);
      end
      chk(een, 8'h01);
      rd(0, 2);
      susp <= 1;
      wb(1, 5'h0c, 32'hff);
      for (i = 0; i < 2; i++) begin
         k <= 1;
         repeat (200 + i * 60) @(posedge clk);
         k <= 0;
         rd(0, 2 + i * 32'h20);
      end
      finish_test;
   end
endmodule
`default_nettype wire
